// ---- rtl/timer_pair_defs.svh ----
// register indices, field positions, codes and reset values of the timer pair
`ifndef TIMER_PAIR_DEFS_SVH
`define TIMER_PAIR_DEFS_SVH
// register indices (byte address = index * 4)
`define TP_IDX_LCTRL     6'h20
`define TP_IDX_UCTRL     6'h21
`define TP_IDX_LCMP      6'h22
`define TP_IDX_UCMP      6'h23
`define TP_IDX_LPW       6'h24
`define TP_IDX_UPW       6'h25
`define TP_IDX_CFG       6'h26
`define TP_IDX_STAT      6'h27
// control register fields
`define TP_FF_BIT        7
`define TP_RUN_BIT       3
`define TP_CTRL_RESET    8'h00
`define TP_BYTE_RESET    8'h00
// clock select codes
`define TP_CK_EVENT      3'b111
// prescaler taps for codes 000..011
`define TP_SHIFT_000     4'd11
`define TP_SHIFT_001     4'd7
`define TP_SHIFT_010     4'd5
`define TP_SHIFT_011     4'd3
`define TP_PRESC_ONES    12'hfff
`define TP_CNT_MAX       8'hff
`endif

// ---- rtl/timer_pair_pkg.sv ----
// types shared by the cascadable timer pair
package timer_pair_pkg;
	// stage operating modes
	typedef enum logic [2:0] {
		MODE_TIMER8  = 3'b000,
		MODE_DIV8    = 3'b001,
		MODE_PWM8    = 3'b010,
		MODE_CASC    = 3'b011,
		MODE_TIMER16 = 3'b100,
		MODE_WARMUP  = 3'b101,
		MODE_PWM16   = 3'b110,
		MODE_RSVD    = 3'b111
	} mode_t;
	// stage control register layout
	typedef struct packed {
		logic        ff_init;
		logic [2:0]  clk_sel;
		logic        run;
		mode_t       mode;
	} ctrl_t;
	// avalon request from master
	typedef struct packed {
		logic        read;
		logic        write;
		logic [7:0]  address;
		logic [3:0]  byteenable;
		logic [31:0] writedata;
	} avalon_req_t;
endpackage : timer_pair_pkg

// ---- rtl/timer_pair.sv ----
// cascadable pair of 8-bit up-counters with avalon register access
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
`include "timer_pair_defs.svh"

module timer_pair (
	input  wire logic                        clk_i,
	input  wire logic                        rst_n_i,
	input  wire timer_pair_pkg::avalon_req_t av_req_i,
	output logic                             av_waitrequest_o,
	output logic [31:0]                      av_readdata_o,
	input  wire logic [1:0]                  event_input_pin_i,
	output logic [1:0]                       stage_match_interrupt_o,
	output logic [1:0]                       stage_ff_o
);
	import timer_pair_pkg::*;

	// ************************************************************
	// state
	// ************************************************************
	ctrl_t        ctrl_r [2];          // lower, upper control
	logic [7:0]   cmp_r [2];           // compare_period_reg per stage
	logic [7:0]   pw_r [2];            // pulse_width_reg as written
	logic [7:0]   pw_act_r [2];        // pulse width in use
	logic [7:0]   cnt_r [2];           // up-counters
	logic [7:0]   cnt_nxt [2];         // next counter values
	logic [1:0]   ff_r;                // timer flip-flops
	logic [1:0]   tgl_nxt;             // flip-flop toggle requests
	logic [1:0]   match_r;             // match pulses
	logic [1:0]   match_nxt;           // next match pulses
	logic [1:0]   pwload_nxt;          // pulse width reload
	logic         halve_r;             // prescale_halving_select
	logic [11:0]  presc_r;             // free-running prescaler
	logic [1:0]   ev_s1_r;             // pin sync stage one
	logic [1:0]   ev_s2_r;             // pin sync stage two
	logic [1:0]   ev_d_r;              // delayed for edge detect
	logic [1:0]   ev_fall;             // falling edge ticks
	logic [1:0]   tick;                // qualified source ticks
	logic [1:0]   run;                 // effective run per stage
	logic         casc;                // 16-bit cascade active
	logic         carry;               // lower overflow into upper
	logic         waitreq_r;           // waitrequest flop
	logic [31:0]  rdata_r;             // read data flop
	logic         acc;                 // request accepted this edge
	logic         wr_ok;               // write takes effect
	logic [5:0]   idx;                 // register index
	logic [15:0]  cnt16;               // cascaded count
	logic [15:0]  cnt16_inc;           // cascaded count plus one

	// ************************************************************
	// avalon slave
	// ************************************************************
	assign idx   = av_req_i.address[7:2];
	assign acc   = (av_req_i.read | av_req_i.write) & ~waitreq_r;
	assign wr_ok = acc & av_req_i.write & av_req_i.byteenable[0];

	// one wait cycle, then answer
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			waitreq_r <= 1'b1;
		else
			waitreq_r <= ~((av_req_i.read | av_req_i.write) & waitreq_r);
	end

	// read data captured during the wait cycle
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			rdata_r <= 32'h0000_0000;
		else if (av_req_i.read & waitreq_r)
		begin
			unique case (idx)
				`TP_IDX_LCTRL: rdata_r <= {24'h00_0000, ctrl_r[0]};
				`TP_IDX_UCTRL: rdata_r <= {24'h00_0000, ctrl_r[1]};
				`TP_IDX_LCMP:  rdata_r <= {24'h00_0000, cmp_r[0]};
				`TP_IDX_UCMP:  rdata_r <= {24'h00_0000, cmp_r[1]};
				`TP_IDX_LPW:   rdata_r <= {24'h00_0000, pw_act_r[0]};
				`TP_IDX_UPW:   rdata_r <= {24'h00_0000, pw_act_r[1]};
				`TP_IDX_CFG:   rdata_r <= {31'h0000_0000, halve_r};
				`TP_IDX_STAT:  rdata_r <= {16'h0000, cnt_r[1], cnt_r[0]};
				default:       rdata_r <= 32'h0000_0000;  // unmapped
			endcase
		end
	end

	assign av_waitrequest_o = waitreq_r;
	assign av_readdata_o    = rdata_r;

	// control, compare, width and config writes
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			ctrl_r[0] <= `TP_CTRL_RESET;
			ctrl_r[1] <= `TP_CTRL_RESET;
			cmp_r[0]  <= `TP_BYTE_RESET;
			cmp_r[1]  <= `TP_BYTE_RESET;
			pw_r[0]   <= `TP_BYTE_RESET;
			pw_r[1]   <= `TP_BYTE_RESET;
			halve_r   <= 1'b0;
		end
		else if (wr_ok)
		begin
			unique case (idx)
				// all fields load together, so a starting write sets mode too
				`TP_IDX_LCTRL: ctrl_r[0] <= av_req_i.writedata[7:0];
				`TP_IDX_UCTRL: ctrl_r[1] <= av_req_i.writedata[7:0];
				`TP_IDX_LCMP:  cmp_r[0]  <= av_req_i.writedata[7:0];
				`TP_IDX_UCMP:  cmp_r[1]  <= av_req_i.writedata[7:0];
				`TP_IDX_LPW:   pw_r[0]   <= av_req_i.writedata[7:0];
				`TP_IDX_UPW:   pw_r[1]   <= av_req_i.writedata[7:0];
				`TP_IDX_CFG:   halve_r   <= av_req_i.writedata[0];
				default:       ;  // unmapped write ignored
			endcase
		end
	end

	// ************************************************************
	// clock sources
	// ************************************************************
	// free-running prescaler of the system clock
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			presc_r <= 12'h000;
		else
			presc_r <= 12'(presc_r + 12'h001);
	end

	// event pins: two flops then an edge register
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			ev_s1_r <= 2'b11;
			ev_s2_r <= 2'b11;
			ev_d_r  <= 2'b11;
		end
		else
		begin
			ev_s1_r <= event_input_pin_i;
			ev_s2_r <= ev_s1_r;
			ev_d_r  <= ev_s2_r;
		end
	end
	assign ev_fall = ev_d_r & ~ev_s2_r;

	// one-cycle tick when the selected tap wraps
	function automatic logic src_tick(input logic [2:0] sel, input logic [11:0] p,
		input logic h, input logic ev);
		logic [3:0]  sh;
		logic [11:0] mask;
		sh   = 4'd0;
		mask = 12'h000;
		unique case (sel)
			3'b000: sh = 4'(`TP_SHIFT_000 + {3'b000, h});
			3'b001: sh = 4'(`TP_SHIFT_001 + {3'b000, h});
			3'b010: sh = 4'(`TP_SHIFT_010 + {3'b000, h});
			3'b011: sh = 4'(`TP_SHIFT_011 + {3'b000, h});
			default: sh = 4'd0;
		endcase
		mask = ~(`TP_PRESC_ONES << sh);
		if (sel == `TP_CK_EVENT)
			return ev;
		else if (sel[2])
			return 1'b0;  // unused codes never tick
		else
			return &(p | ~mask);
	endfunction : src_tick

	// ************************************************************
	// counting
	// ************************************************************
	assign casc      = ctrl_r[1].mode[2];
	assign run[0]    = casc ? ctrl_r[1].run : ctrl_r[0].run;
	assign run[1]    = ctrl_r[1].run;
	assign tick[0]   = src_tick(ctrl_r[0].clk_sel, presc_r, halve_r, ev_fall[0]);
	assign carry     = tick[0] & (cnt_r[0] == `TP_CNT_MAX);
	assign tick[1]   = casc ? carry :
		src_tick(ctrl_r[1].clk_sel, presc_r, halve_r, ev_fall[1]);
	assign cnt16     = {cnt_r[1], cnt_r[0]};
	assign cnt16_inc = 16'(cnt16 + 16'h0001);

	// next counter, match and toggle per stage
	always_comb
	begin
		for (int i = 0; i < 2; i++)
		begin
			cnt_nxt[i]    = cnt_r[i];
			match_nxt[i]  = 1'b0;
			tgl_nxt[i]    = 1'b0;
			pwload_nxt[i] = ~run[i];
		end
		if (casc)
		begin
			// sixteen-bit count on lower source, match on both compares
			if (tick[0])
			begin
				if (cnt16_inc == {cmp_r[1], cmp_r[0]})
				begin
					cnt_nxt[0]   = 8'h00;
					cnt_nxt[1]   = 8'h00;
					match_nxt[1] = 1'b1;
				end
				else
				begin
					cnt_nxt[0] = cnt16_inc[7:0];
					cnt_nxt[1] = cnt16_inc[15:8];
				end
			end
		end
		for (int i = 0; i < 2; i++)
		begin
			if (!casc && tick[i])
			begin
				unique case (ctrl_r[i].mode)
					MODE_TIMER8, MODE_DIV8:
						if (8'(cnt_r[i] + 8'h01) == cmp_r[i])
						begin
							cnt_nxt[i]   = 8'h00;
							match_nxt[i] = 1'b1;
							tgl_nxt[i]   = (ctrl_r[i].mode == MODE_DIV8);
						end
						else
							cnt_nxt[i] = 8'(cnt_r[i] + 8'h01);
					MODE_PWM8:
					begin
						cnt_nxt[i] = 8'(cnt_r[i] + 8'h01);
						if (cnt_r[i] == `TP_CNT_MAX)
						begin
							match_nxt[i]  = 1'b1;
							tgl_nxt[i]    = 1'b1;
							pwload_nxt[i] = 1'b1;
						end
						else if (8'(cnt_r[i] + 8'h01) == pw_act_r[i])
							tgl_nxt[i] = 1'b1;
					end
					default: cnt_nxt[i] = cnt_r[i];  // lower half of cascade
				endcase
			end
			if (!run[i])
			begin
				cnt_nxt[i]   = 8'h00;
				match_nxt[i] = 1'b0;
				tgl_nxt[i]   = 1'b0;
			end
		end
	end

	// counters and match pulses
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			cnt_r[0] <= `TP_BYTE_RESET;
			cnt_r[1] <= `TP_BYTE_RESET;
			match_r  <= 2'b00;
		end
		else
		begin
			cnt_r[0] <= cnt_nxt[0];
			cnt_r[1] <= cnt_nxt[1];
			match_r  <= match_nxt;
		end
	end
	assign stage_match_interrupt_o = match_r;

	// pulse width shifts in at period end or while stopped
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			pw_act_r[0] <= `TP_BYTE_RESET;
			pw_act_r[1] <= `TP_BYTE_RESET;
		end
		else
		begin
			for (int i = 0; i < 2; i++)
				if (pwload_nxt[i])
					pw_act_r[i] <= pw_r[i];
		end
	end

	// timer flip-flops: control write loads, events toggle
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			ff_r <= 2'b00;
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				if (wr_ok && idx == 6'(`TP_IDX_LCTRL + i))
					ff_r[i] <= av_req_i.writedata[`TP_FF_BIT];
				else if (tgl_nxt[i])
					ff_r[i] <= ~ff_r[i];
			end
		end
	end
	assign stage_ff_o = ff_r;

	// ************************************************************
	// checks
	// ************************************************************
	ctrl_reset_a: assert property (@(posedge clk_i)
		!rst_n_i |=> ctrl_r[1] == `TP_CTRL_RESET)
		else $error("upper control not zero after reset");
	ff_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wr_ok && idx == `TP_IDX_UCTRL |=> ff_r[1] == $past(av_req_i.writedata[7]))
		else $error("flip-flop not loaded by control write");
	stop_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!run[1] ##1 !run[1] |-> cnt_r[1] == 8'h00)
		else $error("stopped counter not cleared");
	start_fields_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wr_ok && idx == `TP_IDX_UCTRL && !ctrl_r[1].run && av_req_i.writedata[3]
		|=> ctrl_r[1].run && ctrl_r[1].mode == $past(av_req_i.writedata[2:0]))
		else $error("starting write did not load mode");
	cascade_clk_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		casc && run[1] && !tick[0] |=> $stable(cnt_r[1]))
		else $error("upper counted without cascade carry");
	casc_run_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		casc && !ctrl_r[1].run |=> cnt_r[0] == 8'h00)
		else $error("lower ran without upper run bit");
	match_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		match_r[1] |-> cnt_r[1] == 8'h00)
		else $error("match without counter clear");
	compare_now_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!casc && run[1] && ctrl_r[1].mode == MODE_TIMER8 && tick[1]
		&& 8'(cnt_r[1] + 8'h01) == cmp_r[1] |=> match_r[1])
		else $error("compare match missed");
	event_once_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!casc && run[1] && !tick[1] |=> $stable(cnt_r[1]))
		else $error("counter moved without a source tick");
	tap_map_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!casc && tick[1] && ctrl_r[1].clk_sel == 3'b000 && !halve_r
		|-> presc_r[10:0] == 11'h7ff)
		else $error("wrong prescaler tap");
	div_toggle_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		match_r[1] && !casc && ctrl_r[1].mode == MODE_DIV8 && !$past(wr_ok)
		|-> ff_r[1] != $past(ff_r[1]))
		else $error("divider flip-flop did not toggle");
	cov_match8_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		!casc && match_r[1]);
	cov_casc_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		casc && match_r[1]);
	cov_event_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		ctrl_r[0].clk_sel == `TP_CK_EVENT && ev_fall[0] && run[0]);
endmodule : timer_pair

// ---- testbench/cascadable_8bit_timer_pair_tb.sv ----
// self-checking bench for the cascadable timer pair
`timescale 1ns/1ps
`include "timer_pair_defs.svh"
module cascadable_8bit_timer_pair_tb;
	import timer_pair_pkg::*;
	// *****************
	// signals
	// *****************
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	avalon_req_t av_req_i = '0;
	logic        av_waitrequest_o;
	logic [31:0] av_readdata_o;
	logic [1:0]  event_input_pin_i = 2'b11;       // pins idle high
	logic [1:0]  stage_match_interrupt_o;
	logic [1:0]  stage_ff_o;
	int          errors = 0;
	int          total_checks = 0;
	int          n;                               // cycles seen by wm
	int          mcnt = 0;                        // upper match pulses
	logic [31:0] rdata;
	// one register access and its readback
	typedef struct packed {
		logic [5:0] idx;
		logic [3:0] be;
		logic [7:0] wd;
		logic [7:0] ex;
	} row_t;
	row_t rows [7] = '{
		'{`TP_IDX_LCMP, 4'h1, 8'h5a, 8'h5a},
		'{`TP_IDX_UCMP, 4'h1, 8'ha5, 8'ha5},
		'{`TP_IDX_UCMP, 4'h0, 8'h11, 8'ha5},      // byte lane off, ignored
		'{`TP_IDX_UCTRL, 4'h1, 8'h97, 8'h97},
		'{`TP_IDX_UCTRL, 4'h1, 8'h00, 8'h00},
		'{6'h10, 4'h1, 8'hff, 8'h00},             // unmapped place
		'{`TP_IDX_STAT, 4'h1, 8'hff, 8'h00}       // read-only status
	};
	int per [4] = '{2048, 128, 32, 8};            // tick spacing per code
	// clock of 4 ns
	always #2 clk_i = ~clk_i;
	// counts upper match pulses
	always @(posedge clk_i)
		if (stage_match_interrupt_o[1] === 1'b1)
			mcnt++;
	timer_pair dut (
		.clk_i                   (clk_i),
		.rst_n_i                 (rst_n_i),
		.av_req_i                (av_req_i),
		.av_waitrequest_o        (av_waitrequest_o),
		.av_readdata_o           (av_readdata_o),
		.event_input_pin_i       (event_input_pin_i),
		.stage_match_interrupt_o (stage_match_interrupt_o),
		.stage_ff_o              (stage_ff_o)
	);
	// *****************
	// tasks
	// *****************
	// compare and count
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// one avalon transfer, held until waitrequest samples low
	task bus(input logic rd, input logic [5:0] idx, input logic [3:0] be, input logic [7:0] wd);
		@(posedge clk_i);
		av_req_i.read <= rd;
		av_req_i.write <= ~rd;
		av_req_i.address <= {idx, 2'b00};
		av_req_i.byteenable <= be;
		av_req_i.writedata <= {24'h0, wd};
		// no cycle count assumed; only the watchdog ends a hang
		do
			@(posedge clk_i);
		while (av_waitrequest_o !== 1'b0);
		rdata = av_readdata_o;
		av_req_i <= '0;
	endtask : bus
	task wr(input logic [5:0] idx, input logic [7:0] wd);
		bus(1'b0, idx, 4'h1, wd);
	endtask : wr
	task rd(input logic [5:0] idx);
		bus(1'b1, idx, 4'h1, 8'h00);
	endtask : rd
	// waits for the next match pulse of a stage, bounded
	task wm(input int s);
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (stage_match_interrupt_o[s] !== 1'b1 && n < 5000);
	endtask : wm
	// one falling edge on a stage's pin, low held four cycles, then high six
	task fall(input int s);
		@(posedge clk_i);
		event_input_pin_i[s] <= 1'b0;
		repeat (4) @(posedge clk_i);
		event_input_pin_i[s] <= 1'b1;
		repeat (6) @(posedge clk_i);
	endtask : fall
	// verdict and end of run
	task results;
		if (errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : results
	// *****************
	// watchdog
	// *****************
	initial
	begin
		repeat (40000) @(posedge clk_i);
		errors++;
		results();
	end
	// *****************
	// main sequence
	// *****************
	initial
	begin
		repeat (6) @(posedge clk_i);
		chk(av_waitrequest_o, 1'b1);
		chk(stage_match_interrupt_o, 2'b00);
		chk(stage_ff_o, 2'b00);
		rst_n_i <= 1'b1;
		rd(`TP_IDX_UCTRL);
		chk(rdata, 32'h0);
		// table of accesses
		foreach (rows[i])
		begin
			bus(1'b0, rows[i].idx, rows[i].be, rows[i].wd);
			rd(rows[i].idx);
			chk(rdata, {24'h0, rows[i].ex});
		end
		// every mode code, stopped
		for (int m = 0; m < 8; m++)
		begin
			wr(`TP_IDX_UCTRL, {5'h0, m[2:0]});
			rd(`TP_IDX_UCTRL);
			chk(rdata, {29'h0, m[2:0]});
		end
		// flip-flop set and clear by write
		wr(`TP_IDX_UCTRL, 8'h80);
		@(posedge clk_i);
		chk(stage_ff_o[1], 1'b1);
		wr(`TP_IDX_UCTRL, 8'h00);
		@(posedge clk_i);
		chk(stage_ff_o[1], 1'b0);
		// each internal tap, compare 1 gives a match per tick
		wr(`TP_IDX_UCMP, 8'h01);
		for (int c = 0; c < 4; c++)
		begin
			wr(`TP_IDX_UCTRL, {1'b0, c[2:0], 4'h8});
			wm(1);
			wm(1);
			chk(n, per[c]);
			wr(`TP_IDX_UCTRL, {1'b0, c[2:0], 4'h0});
		end
		// halving doubles the fastest tap
		wr(`TP_IDX_CFG, 8'h01);
		wr(`TP_IDX_UCTRL, 8'h38);
		wm(1);
		wm(1);
		chk(n, 16);
		wr(`TP_IDX_UCTRL, 8'h30);
		wr(`TP_IDX_CFG, 8'h00);
		// timer period of compare 3, then a compare change while running
		wr(`TP_IDX_UCMP, 8'h03);
		wr(`TP_IDX_UCTRL, 8'h38);
		wm(1);
		wm(1);
		chk(n, 24);
		wr(`TP_IDX_UCMP, 8'h05);
		wm(1);
		wm(1);
		chk(n, 40);
		// stop clears the count
		wr(`TP_IDX_UCTRL, 8'h30);
		rd(`TP_IDX_STAT);
		chk(rdata[15:8], 8'h00);
		// event counting on falling pin edges, compare 2
		wr(`TP_IDX_UCMP, 8'h02);
		wr(`TP_IDX_UCTRL, 8'h78);
		mcnt = 0;
		fall(1);
		rd(`TP_IDX_STAT);
		chk(rdata[15:8], 8'h01);
		chk(mcnt, 0);
		fall(1);
		rd(`TP_IDX_STAT);
		chk(rdata[15:8], 8'h00);
		chk(mcnt, 1);
		wr(`TP_IDX_UCTRL, 8'h70);
		// cascade: lower tap 011, upper mode 100 with ignored tap 000
		wr(`TP_IDX_LCMP, 8'h01);
		wr(`TP_IDX_UCMP, 8'h01);
		wr(`TP_IDX_LCTRL, 8'h33);
		wr(`TP_IDX_LPW, 8'h02);
		wr(`TP_IDX_UPW, 8'h00);
		rd(`TP_IDX_LPW);
		chk(rdata, 32'h0000_0002);
		wr(`TP_IDX_UCTRL, 8'h0c);
		wm(1);
		wm(1);
		chk(n, 2056);
		wr(`TP_IDX_UCTRL, 8'h04);
		// lower stage alone: its own event pin, then pwm
		wr(`TP_IDX_UCTRL, 8'h00);
		wr(`TP_IDX_LCMP, 8'h02);
		wr(`TP_IDX_LCTRL, 8'h78);
		fall(0);
		rd(`TP_IDX_STAT);
		chk(rdata, 32'h0000_0001);
		wr(`TP_IDX_LCTRL, 8'h70);
		wr(`TP_IDX_LPW, 8'h80);
		wr(`TP_IDX_LCTRL, 8'h3a);
		wm(0);
		// new width waits for the period end
		wr(`TP_IDX_LPW, 8'h40);
		rd(`TP_IDX_LPW);
		chk(rdata, 32'h0000_0080);
		wm(0);
		wm(0);
		chk(n, 2048);
		// width 0x40 at tap 011: flip-flop turns after 64 ticks of 8 cycles
		repeat (511) @(posedge clk_i);
		chk(stage_ff_o[0], 1'b0);
		@(posedge clk_i);
		chk(stage_ff_o[0], 1'b1);
		rd(`TP_IDX_LPW);
		chk(rdata, 32'h0000_0040);
		wr(`TP_IDX_LCTRL, 8'h32);
		// divider output on the upper stage, then a reset while it runs
		wr(`TP_IDX_UCMP, 8'h02);
		wr(`TP_IDX_UCTRL, 8'hb9);
		wm(1);
		chk(stage_ff_o[1], 1'b0);
		wm(1);
		chk(n, 16);
		chk(stage_ff_o[1], 1'b1);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk(av_waitrequest_o, 1'b1);
		chk(stage_match_interrupt_o, 2'b00);
		chk(stage_ff_o, 2'b00);
		rst_n_i <= 1'b1;
		rd(`TP_IDX_UCTRL);
		chk(rdata, 32'h0);
		rd(`TP_IDX_STAT);
		chk(rdata, 32'h0);
		results();
	end
endmodule : cascadable_8bit_timer_pair_tb
